/* File: src/pbcs_defs.vh */
// register offsets, field positions and reset values of the loop control
`ifndef PBCS_DEFS_VH
`define PBCS_DEFS_VH

`define PBCS_ADDR_W          8
`define PBCS_DATA_W          8

`define PBCS_OFS_CTRL        8'h36
`define PBCS_OFS_BW          8'h37
`define PBCS_OFS_MULH        8'h38
`define PBCS_OFS_MULL        8'h39
`define PBCS_OFS_RANGE       8'h3A
`define PBCS_OFS_RDIV        8'h3B

`define PBCS_CTRL_IRQ_EN     7
`define PBCS_CTRL_IRQ_PEND   6
`define PBCS_CTRL_PWR_ON     5
`define PBCS_CTRL_BCS        4
`define PBCS_CTRL_PRE_HI     3
`define PBCS_CTRL_PRE_LO     2
`define PBCS_CTRL_VPR_HI     1
`define PBCS_CTRL_VPR_LO     0

`define PBCS_BW_AUTO         7
`define PBCS_BW_LOCK         6
`define PBCS_BW_TRACK        5

`define PBCS_RST_PRE         2'h0
`define PBCS_RST_VPR         2'h0
`define PBCS_RST_MULH        4'h0
`define PBCS_RST_MULL        8'h40
`define PBCS_RST_RANGE       8'h40
`define PBCS_RST_RDIV        4'h1

`define PBCS_SWITCH_EDGES    2'h3

`endif

/* File: src/pbcs_top.v */
// loop bandwidth control, lock detection and base clock selector
// Function
// RULE_01: auto mode lets the lock detector pick acquisition or tracking itself.
// RULE_02: auto mode makes tracking bit read-only, set/cleared by frequency tolerance.
// RULE_03: auto mode makes lock flag read-only, set/cleared by frequency tolerance.
// RULE_04: auto mode with irq enable raises an interrupt on every lock toggle.
// RULE_05: manual mode makes tracking bit writable; 0 acquisition, 1 tracking.
// RULE_06: software clears tracking bit before powering the loop in manual mode.
// RULE_07: software waits acquisition time after power-on before setting tracking.
// RULE_08: software waits lock time after tracking before selecting vco clock.
// RULE_09: manual mode disables lock flag and all interrupts.
// RULE_10: zero reference divider or multiplier behaves exactly as one.
// RULE_11: zero vco range disables loop and forces crystal as base clock.
// RULE_12: source change waits three edges of each clock, output held still; old vco edges are skipped once the loop stops mid-switch.
// RULE_13: selected source is divided by two for a 50 percent base clock.
// RULE_14: base select chooses crystal or vco; vco refused while loop off.
// RULE_15: loop power-on cannot be cleared while vco clock is selected.
// RULE_16: power change and vco select change never take effect together; one write setting select and clearing power-on changes both.
// RULE_17: software places P, E, N, L and R in their own fields.
// RULE_18: software never programs the range power field to three.
// RULE_19: loop settles vco at reference times 2^P times N over R.
// RULE_20: manual mode forces lock irq enable clear and read-only.
// RULE_21: loop off or zero range forces base select clear and read-only.
// RULE_22: base select set forces loop power-on set and read-only.
// RULE_23: loop on makes multiplier, range and divider registers read-only.
// RULE_24: lock interrupt stays until pending flag cleared, gated by enable.
`include "pbcs_defs.vh"

module pbcs_top
#(
    parameter LOCK_MATCHES = 4
)
(
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire [`PBCS_ADDR_W-1:0] addr,
    input  wire [`PBCS_DATA_W-1:0] wdata,
    input  wire                    wr,
    input  wire                    rd,
    output reg  [`PBCS_DATA_W-1:0] rdata,
    input  wire                    crystal_clk,
    input  wire                    vco_clk,
    output wire                    vco_enable,
    output wire                    filter_track,
    output wire                    base_clk_out,
    output wire                    base_switching,
    output wire                    lock_irq
);

////////////////////////////////////////////////////////////////////////////
// helpers

function [11:0] zero_as_one;
    input [11:0] val;
    begin
        zero_as_one = (val == 12'h000) ? 12'h001 : val;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// register state

reg        irq_en_ff;
reg        irq_pend_ff;
reg        pwr_on_ff;
reg        bcs_ff;
reg  [1:0] pre_ff;
reg  [1:0] vpr_ff;
reg        auto_ff;
reg        track_man_ff;
reg  [3:0] mulh_ff;
reg  [7:0] mull_ff;
reg  [7:0] range_ff;
reg  [3:0] rdiv_ff;
reg        lock_ff;
reg        in_tol_ff;

wire       wr_ctrl   = wr && (addr == `PBCS_OFS_CTRL);
wire       wr_bw     = wr && (addr == `PBCS_OFS_BW);
wire       range_ok  = (range_ff != 8'h00);
wire       loop_run  = pwr_on_ff && range_ok;                  // RULE_11
wire       prog_open = !pwr_on_ff;                             // RULE_23
wire       nxt_auto  = wr_bw ? wdata[`PBCS_BW_AUTO] : auto_ff;
// lock follows the new auto bit so it never reads set in manual mode
wire       nxt_lock  = nxt_auto && in_tol_ff;                  // RULE_03
wire       lock_togl = auto_ff && (nxt_lock != lock_ff);       // RULE_04

// select takes the old power bit, power takes the old select bit
wire       nxt_bcs   = wr_ctrl ? (wdata[`PBCS_CTRL_BCS] && pwr_on_ff)
                               : bcs_ff;                       // RULE_16
wire       nxt_pwr   = bcs_ff ? 1'b1                           // RULE_22
                     : (wr_ctrl ? wdata[`PBCS_CTRL_PWR_ON] : pwr_on_ff);

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        irq_en_ff    <= 1'b0;
        irq_pend_ff  <= 1'b0;
        pwr_on_ff    <= 1'b1;
        bcs_ff       <= 1'b0;
        pre_ff       <= `PBCS_RST_PRE;
        vpr_ff       <= `PBCS_RST_VPR;
        auto_ff      <= 1'b0;
        track_man_ff <= 1'b0;
        mulh_ff      <= `PBCS_RST_MULH;
        mull_ff      <= `PBCS_RST_MULL;
        range_ff     <= `PBCS_RST_RANGE;
        rdiv_ff      <= `PBCS_RST_RDIV;
        lock_ff      <= 1'b0;
    end
    else
    begin
        pwr_on_ff <= nxt_pwr;                                  // RULE_15
        bcs_ff    <= nxt_bcs && pwr_on_ff && range_ok;         // RULE_14 RULE_21
        auto_ff   <= nxt_auto;
        lock_ff   <= nxt_lock;                                 // RULE_09
        if (!nxt_auto)
            irq_en_ff <= 1'b0;                                 // RULE_20
        else if (wr_ctrl)
            irq_en_ff <= wdata[`PBCS_CTRL_IRQ_EN];
        // a toggle in the clearing cycle still sets the flag
        if (!nxt_auto)
            irq_pend_ff <= 1'b0;                               // RULE_09
        else if (lock_togl)
            irq_pend_ff <= 1'b1;                               // RULE_04
        else if (wr_ctrl && !wdata[`PBCS_CTRL_IRQ_PEND])
            irq_pend_ff <= 1'b0;                               // RULE_24
        if (wr_bw && !auto_ff)
            track_man_ff <= wdata[`PBCS_BW_TRACK];             // RULE_05
        if (wr_ctrl && prog_open)
        begin
            pre_ff <= wdata[`PBCS_CTRL_PRE_HI:`PBCS_CTRL_PRE_LO]; // RULE_23
            vpr_ff <= wdata[`PBCS_CTRL_VPR_HI:`PBCS_CTRL_VPR_LO];
        end
        if (wr && prog_open && addr == `PBCS_OFS_MULH)
            mulh_ff <= wdata[3:0];                             // RULE_23
        if (wr && prog_open && addr == `PBCS_OFS_MULL)
            mull_ff <= wdata;                                  // RULE_23
        if (wr && prog_open && addr == `PBCS_OFS_RANGE)
            range_ff <= wdata;                                 // RULE_23
        if (wr && prog_open && addr == `PBCS_OFS_RDIV)
            rdiv_ff <= wdata[3:0];                             // RULE_23
    end
end

assign lock_irq     = irq_pend_ff && irq_en_ff;                // RULE_24
assign vco_enable   = loop_run;                                // RULE_11
// auto mode follows the detector, manual mode follows software
assign filter_track = auto_ff ? lock_ff : track_man_ff;        // RULE_01 RULE_02

////////////////////////////////////////////////////////////////////////////
// read port

reg [`PBCS_DATA_W-1:0] rd_mux;

always @*
begin
    case (addr)
        `PBCS_OFS_CTRL:  rd_mux = {irq_en_ff, irq_pend_ff, pwr_on_ff,
                                   bcs_ff, pre_ff, vpr_ff};
        `PBCS_OFS_BW:    rd_mux = {auto_ff, lock_ff, filter_track,
                                   5'h00};                     // RULE_02
        `PBCS_OFS_MULH:  rd_mux = {4'h0, mulh_ff};
        `PBCS_OFS_MULL:  rd_mux = mull_ff;
        `PBCS_OFS_RANGE: rd_mux = range_ff;
        `PBCS_OFS_RDIV:  rd_mux = {4'h0, rdiv_ff};
        default:         rd_mux = 8'h00;
    endcase
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        rdata <= 8'h00;
    else if (rd)
        rdata <= rd_mux;
end

////////////////////////////////////////////////////////////////////////////
// dividers and lock detector

reg         xtal_prev_ff;
reg         vco_prev_ff;
reg  [3:0]  ref_cnt_ff;
reg  [14:0] fb_cnt_ff;
reg  [1:0]  fb_seen_ff;
reg  [7:0]  match_ff;

wire        xtal_rise = crystal_clk && !xtal_prev_ff;
wire        vco_rise  = vco_clk && !vco_prev_ff && loop_run;
wire [11:0] r_eff     = zero_as_one({8'h00, rdiv_ff});         // RULE_10
wire [11:0] n_eff     = zero_as_one({mulh_ff, mull_ff});       // RULE_10
wire [14:0] fb_top    = ({3'h0, n_eff} << pre_ff) - 15'h0001;  // RULE_19
wire        ref_tick  = xtal_rise && (ref_cnt_ff == r_eff[3:0] - 4'h1);
wire        fb_tick   = vco_rise && (fb_cnt_ff == fb_top);
wire [1:0]  fb_total  = fb_seen_ff + {1'b0, fb_tick};
wire        win_good  = (fb_total == 2'h1);

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        xtal_prev_ff <= 1'b0;
        vco_prev_ff  <= 1'b0;
        ref_cnt_ff   <= 4'h0;
        fb_cnt_ff    <= 15'h0000;
        fb_seen_ff   <= 2'h0;
        match_ff     <= 8'h00;
        in_tol_ff    <= 1'b0;
    end
    else
    begin
        xtal_prev_ff <= crystal_clk;
        vco_prev_ff  <= vco_clk;
        if (!loop_run)
        begin
            ref_cnt_ff <= 4'h0;
            fb_cnt_ff  <= 15'h0000;
            fb_seen_ff <= 2'h0;
            match_ff   <= 8'h00;
            in_tol_ff  <= 1'b0;
        end
        else
        begin
            if (xtal_rise)
                ref_cnt_ff <= ref_tick ? 4'h0 : ref_cnt_ff + 4'h1;
            if (vco_rise)
                fb_cnt_ff <= fb_tick ? 15'h0000 : fb_cnt_ff + 15'h0001;
            if (ref_tick)
            begin
                // one feedback edge per reference period, for LOCK_MATCHES periods in a row, means in tolerance
                fb_seen_ff <= 2'h0;
                if (!win_good)
                    match_ff <= 8'h00;
                else if (match_ff != LOCK_MATCHES[7:0])
                    match_ff <= match_ff + 8'h01;
                in_tol_ff <= win_good
                          && (match_ff >= LOCK_MATCHES[7:0] - 8'h01);
            end
            else if (fb_tick && fb_seen_ff != 2'h3)
                fb_seen_ff <= fb_seen_ff + 2'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// glitch-free base clock selector

localparam SW_RUN = 2'h0;
localparam SW_OLD = 2'h1;
localparam SW_NEW = 2'h2;

reg        sel_cur_ff;
reg  [1:0] sw_state_ff;
reg  [1:0] edge_cnt_ff;
reg        out_ff;

// range zero or loop off pulls the request back to the crystal
wire       sel_req  = bcs_ff && loop_run;                      // RULE_11
wire       old_rise = sel_cur_ff ? vco_rise : xtal_rise;
wire       new_rise = sel_cur_ff ? xtal_rise : vco_rise;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sel_cur_ff  <= 1'b0;
        sw_state_ff <= SW_RUN;
        edge_cnt_ff <= 2'h0;
        out_ff      <= 1'b0;
    end
    else
    begin
        case (sw_state_ff)
            SW_RUN:
            begin
                if (sel_req != sel_cur_ff)
                begin
                    sw_state_ff <= SW_OLD;                     // RULE_12
                    edge_cnt_ff <= 2'h0;
                end
                else if (old_rise)
                    out_ff <= !out_ff;                         // RULE_13
            end
            SW_OLD:
            begin
                // a stopped source must not hang the switch forever
                if (old_rise || (sel_cur_ff && !loop_run))
                begin
                    if (edge_cnt_ff == `PBCS_SWITCH_EDGES - 2'h1
                        || (sel_cur_ff && !loop_run))
                    begin
                        sw_state_ff <= SW_NEW;                 // RULE_12
                        edge_cnt_ff <= 2'h0;
                    end
                    else
                        edge_cnt_ff <= edge_cnt_ff + 2'h1;
                end
            end
            SW_NEW:
            begin
                // vco stopped before it was reached: stay on the crystal
                if (!sel_cur_ff && !loop_run)
                    sw_state_ff <= SW_RUN;                     // RULE_11
                else if (new_rise)
                begin
                    if (edge_cnt_ff == `PBCS_SWITCH_EDGES - 2'h1)
                    begin
                        sw_state_ff <= SW_RUN;                 // RULE_12
                        sel_cur_ff  <= !sel_cur_ff;
                    end
                    else
                        edge_cnt_ff <= edge_cnt_ff + 2'h1;
                end
            end
            default:
                sw_state_ff <= SW_RUN;
        endcase
    end
end

assign base_clk_out   = out_ff;
assign base_switching = (sw_state_ff != SW_RUN);

endmodule

/* File: bench/pbcs_checker.sv */
// concurrent checks on the loop control ports
`include "pbcs_defs.vh"
module pbcs_checker
#(
    parameter LOCK_MATCHES = 4
)
(
    input wire                    clk,
    input wire                    rst_n,
    input wire [`PBCS_ADDR_W-1:0] addr,
    input wire [`PBCS_DATA_W-1:0] wdata,
    input wire                    wr,
    input wire                    rd,
    input wire [`PBCS_DATA_W-1:0] rdata,
    input wire                    crystal_clk,
    input wire                    vco_clk,
    input wire                    vco_enable,
    input wire                    filter_track,
    input wire                    base_clk_out,
    input wire                    base_switching,
    input wire                    lock_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // auto bit is not visible at a port, so it is shadowed here
    reg  auto_ff;
    wire nxt_auto = (wr && addr == `PBCS_OFS_BW) ?
                    wdata[`PBCS_BW_AUTO] : auto_ff;
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            auto_ff <= 1'b0;
        else
            auto_ff <= nxt_auto;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    sequence s_ctrl_sel;
        rd && addr == `PBCS_OFS_CTRL ##1 rdata[`PBCS_CTRL_BCS];
    endsequence
    sequence s_auto_read;
        rd && addr == `PBCS_OFS_BW ##1 rdata[`PBCS_BW_AUTO];
    endsequence
    sequence s_held;
        base_switching ##1 base_switching;
    endsequence
    property p_manual_quiet;
        !auto_ff |-> !lock_irq;
    endproperty
    property p_irq_holds;
        lock_irq && !wr |=> lock_irq;
    endproperty
    property p_manual_track;
        wr && addr == `PBCS_OFS_BW && !auto_ff && !wdata[7]
            |=> filter_track == $past(wdata[`PBCS_BW_TRACK]);
    endproperty
    property p_sel_refused;
        rd && addr == `PBCS_OFS_CTRL && !vco_enable |=> !rdata[4];
    endproperty
    property p_power_forced;
        s_ctrl_sel |-> rdata[`PBCS_CTRL_PWR_ON];
    endproperty
    property p_manual_lock_clr;
        rd && addr == `PBCS_OFS_BW && !auto_ff |=> rdata[7:6] == 2'h0;
    endproperty
    property p_track_is_lock;
        s_auto_read |-> rdata[`PBCS_BW_TRACK] == rdata[`PBCS_BW_LOCK];
    endproperty
    property p_frozen;
        s_held |-> $stable(base_clk_out);
    endproperty
    property p_switch_bound;
        $rose(base_switching) |-> ##[1:80] !base_switching;
    endproperty
    a_manual_quiet: assert property (p_manual_quiet)
        else $error("lock irq raised in manual mode");
    a_irq_holds: assert property (p_irq_holds)
        else $error("lock irq dropped without a write");
    a_manual_track: assert property (p_manual_track)
        else $error("filter mode not set by manual write");
    a_sel_refused: assert property (p_sel_refused)
        else $error("base select set while loop not running");
    a_power_forced: assert property (p_power_forced)
        else $error("base select set with loop off");
    a_manual_lock_clr: assert property (p_manual_lock_clr)
        else $error("lock bit seen in manual mode");
    a_track_is_lock: assert property (p_track_is_lock)
        else $error("tracking bit differs from lock in auto mode");
    a_frozen: assert property (p_frozen)
        else $error("base clock moved during switch");
    a_switch_bound: assert property (p_switch_bound)
        else $error("source switch did not finish");
endmodule
bind pbcs_top pbcs_checker #(.LOCK_MATCHES(LOCK_MATCHES)) u_chk
(
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .crystal_clk(crystal_clk),
    .vco_clk(vco_clk), .vco_enable(vco_enable),
    .filter_track(filter_track), .base_clk_out(base_clk_out),
    .base_switching(base_switching), .lock_irq(lock_irq)
);

/* File: bench/pbcs_top_bench.sv */
// randomised register and clock selector bench for the loop control
`include "pbcs_defs.vh"
module pbcs_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, wr, rd, crystal_clk, vco_clk;
    logic [7:0]  addr, wdata, d;
    logic [7:0]  rtab [0:7];
    logic [31:0] seed;
    wire  [7:0]  rdata;
    wire         vco_enable, filter_track, base_clk_out;
    wire         base_switching, lock_irq;
    int          failures, n_checks, xper, vper, xcnt, vcnt, i;
    // software settling waits, in clk cycles
    localparam int acquire_wait_time = 20;
    localparam int lock_wait_time    = 20;

    pbcs_top #(.LOCK_MATCHES(2)) u_dut
    (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .crystal_clk(crystal_clk),
        .vco_clk(vco_clk), .vco_enable(vco_enable),
        .filter_track(filter_track), .base_clk_out(base_clk_out),
        .base_switching(base_switching), .lock_irq(lock_irq)
    );
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // both sources synchronous to clk, so toggle counts are exact
    always @(posedge clk)
    begin
        xcnt <= (xcnt >= 2 * xper - 1) ? 0 : xcnt + 1;
        vcnt <= (vcnt >= 2 * vper - 1) ? 0 : vcnt + 1;
        crystal_clk <= xcnt < xper;
        vco_clk <= vcnt < vper;
    end
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function logic [7:0] readback(input logic [7:0] a, input logic [7:0] v);
        return (a == `PBCS_OFS_MULH || a == `PBCS_OFS_RDIV) ? v & 8'h0F : v;
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task wait_sig(input bit want_irq);
        i = 0;
        repeat (2) @(posedge clk);
        #1;
        while ((want_irq ? lock_irq !== 1'b1 : base_switching !== 1'b0)
               && i < 400)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i >= 400)
            failures++;
    endtask
    task count_toggles(input int k, input int per);
        logic       last;
        logic [7:0] n;
        n = 0;
        last = base_clk_out;
        repeat (2 * per * k)
        begin
            @(posedge clk);
            #1;
            if (base_clk_out !== last)
                n++;
            last = base_clk_out;
        end
        chk(n, k[7:0]);
    endtask
    task conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #(100 * 20000);
        failures++;
        conclude;
    end
    ////////////////////////////////////////
    initial
    begin
        {rst_n, wr, rd} = 3'h0;
        {addr, wdata} = 16'h0000;
        {failures, n_checks, xper, vper} = {32'h0, 32'h0, 32'h3, 32'h2};
        seed = 32'h11175C9A;
        rtab = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01, 8'h00};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++)
            rd_chk(8'h35 + i[7:0], rtab[i]);
        for (int j = 0; j < 4; j++)
        begin
            seed = xs(seed);
            wr_reg(8'h38 + j[7:0], seed[7:0]);
            rd_chk(8'h38 + j[7:0], rtab[j + 3]);
        end
        wr_reg(8'h36, 8'h00);
        for (int j = 0; j < 4; j++)
        begin
            seed = xs(seed);
            d = seed[7:0];
            wr_reg(8'h38 + j[7:0], d);
            rd_chk(8'h38 + j[7:0], readback(8'h38 + j[7:0], d));
        end
        wr_reg(8'h37, 8'h20);
        chk(filter_track, 8'h01);
        rd_chk(8'h37, 8'h20);
        wr_reg(8'h37, 8'h00);
        chk(filter_track, 8'h00);
        wr_reg(8'h36, 8'h80);
        rd_chk(8'h36, 8'h00);
        chk(lock_irq, 8'h00);
        wr_reg(8'h3A, 8'h00);
        wr_reg(8'h36, 8'h20);
        wr_reg(8'h36, 8'h30);
        rd_chk(8'h36, 8'h20);
        chk(vco_enable, 8'h00);
        // zero divider and multiplier, usable range
        wr_reg(8'h36, 8'h00);
        for (int j = 0; j < 4; j++)
            wr_reg(8'h38 + j[7:0], j == 2 ? 8'h40 : 8'h00);
        wr_reg(8'h36, 8'h30);
        rd_chk(8'h36, 8'h20);
        repeat (acquire_wait_time) @(posedge clk);
        wr_reg(8'h37, 8'h20);
        chk(filter_track, 8'h01);
        repeat (lock_wait_time) @(posedge clk);
        wr_reg(8'h36, 8'h30);
        rd_chk(8'h36, 8'h30);
        chk(vco_enable, 8'h01);
        wait_sig(1'b0);
        count_toggles(12, vper);
        wr_reg(8'h36, 8'h00);
        rd_chk(8'h36, 8'h20);
        wait_sig(1'b0);
        count_toggles(10, xper);
        // equal rates lock only if zero reads as one
        vper = 3;
        wr_reg(8'h37, 8'h80);
        wr_reg(8'h36, 8'hA0);
        wait_sig(1'b1);
        chk(lock_irq, 8'h01);
        rd_chk(8'h37, 8'hE0);
        chk(filter_track, 8'h01);
        wr_reg(8'h36, 8'hA0);
        chk(lock_irq, 8'h00);
        vper = 6;
        wait_sig(1'b1);
        chk(lock_irq, 8'h01);
        rd_chk(8'h37, 8'h80);
        chk(filter_track, 8'h00);
        wr_reg(8'h37, 8'h00);
        chk(lock_irq, 8'h00);
        rd_chk(8'h36, 8'h20);
        conclude;
    end
endmodule
